// ### logic/cbcs_pkg.sv
`default_nettype none
package cbcs_pkg;
  // ********************************
  // clock and timing
  // ********************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned SECS_PER_HOUR = 3600;
  localparam int unsigned NUM_CELLS     = 8;
  // ********************************
  // register indices (byte address = 4 * index)
  // ********************************
  localparam logic [5:0] IDX_SENSE_RANGE = 6'h07;
  localparam logic [5:0] IDX_CHG_SHORT   = 6'h09;
  localparam logic [5:0] IDX_CELL_BAL    = 6'h0A;
  localparam logic [5:0] IDX_STATUS      = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT    = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h12;
  localparam logic [7:0] RST_CFG         = 8'h00;
  localparam logic [2:0] RST_MASK        = 3'h0;
  // ********************************
  // field positions
  // ********************************
  localparam int DLY_LSB   = 4;
  localparam int TRIP_LSB  = 0;
  localparam int MODE_LSB  = 6;
  localparam int TMO_LSB   = 4;
  localparam int VOLT_LSB  = 0;
  localparam int IRQ_START = 0;
  localparam int IRQ_TMO   = 1;
  localparam int IRQ_STOP  = 2;
  // ********************************
  // modes, decode steps, states
  // ********************************
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_ALWAYS = 2'h1;
  localparam logic [1:0] MODE_CHG    = 2'h2;
  localparam logic [1:0] MODE_CHG_TO = 2'h3;
  localparam logic [9:0]  DLY_STEP_US = 10'h03C;
  localparam logic [8:0]  TRIP0_BASE  = 9'h00A;
  localparam logic [8:0]  TRIP0_STEP  = 9'h005;
  localparam logic [8:0]  TRIP1_BASE  = 9'h032;
  localparam logic [8:0]  TRIP1_STEP  = 9'h019;
  localparam logic [11:0] VOLT_TOP_MV = 12'hF3C;
  localparam logic [11:0] VOLT_STEP   = 12'h064;

  typedef enum logic [1:0] {ST_IDLE, ST_BAL, ST_LOCK} cbcs_state_type;

  function automatic logic [9:0] dly_us(input logic [3:0] sel);
    dly_us = DLY_STEP_US * 10'(sel) + DLY_STEP_US;
  endfunction : dly_us

  function automatic logic [8:0] trip_mv(input logic [3:0] sel, input logic rng);
    trip_mv = rng ? TRIP1_BASE + TRIP1_STEP * 9'(sel) : TRIP0_BASE + TRIP0_STEP * 9'(sel);
  endfunction : trip_mv
endpackage : cbcs_pkg
`default_nettype wire

// ### logic/cbcs_tmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cbcs_tmr_if;
  logic       run;
  logic       clear;
  logic [1:0] sel;
  logic       expired;
  modport ctl (output run, output clear, output sel, input expired);
  modport tmr (input run, input clear, input sel, output expired);
endinterface : cbcs_tmr_if
`default_nettype wire

// ### logic/cbcs_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cbcs_timer #(
  parameter int unsigned TICK_CYCLES   = cbcs_pkg::TICK_CYCLES,
  parameter int unsigned SECS_PER_HOUR = cbcs_pkg::SECS_PER_HOUR
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // control
  cbcs_tmr_if.tmr  tif
);
  logic [24:0] pre_q;
  logic [14:0] sec_q;
  logic        exp_q;
  wire         tick  = pre_q == 25'(TICK_CYCLES - 1);
  wire  [14:0] limit = 15'(SECS_PER_HOUR) << tif.sel;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pre_q <= 25'h0;
      sec_q <= 15'h0;
      exp_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (tif.clear || !tif.run)
      begin
        pre_q <= 25'h0;
        sec_q <= 15'h0;
        exp_q <= 1'b0;
      end
      else if (!exp_q)
      begin
        pre_q <= tick ? 25'h0 : pre_q + 25'h1;
        if (tick)
        begin
          sec_q <= sec_q + 15'h1;
          exp_q <= (sec_q + 15'h1) == limit;
        end
      end
    end
  end
  assign tif.expired = exp_q;

  expiry_tick_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(exp_q) |-> $past(tick) && sec_q == limit)
    else $error("timer expired off its limit");
endmodule : cbcs_timer
`default_nettype wire

// ### logic/cbcs_decode.sv
`timescale 1ns/1ns
`default_nettype none
module cbcs_decode (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // configuration
  input  wire logic [7:0]  i_chg_short_config,
  input  wire logic        i_sense_gain_range,
  input  wire logic [3:0]  i_balance_volt_sel,
  // decoded settings
  output logic      [9:0]  o_delay_us,
  output logic             o_delay_rsvd,
  output logic      [8:0]  o_trip_mv,
  output logic      [11:0] o_volt_mv
);
  wire [3:0] dsel = i_chg_short_config[cbcs_pkg::DLY_LSB +: 4];
  wire [3:0] tsel = i_chg_short_config[cbcs_pkg::TRIP_LSB +: 4];

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_delay_us   <= 10'h0;
      o_delay_rsvd <= 1'b1;
      o_trip_mv    <= 9'h0;
      o_volt_mv    <= 12'h0;
    end
    else if (i_ce)
    begin
      o_delay_us   <= cbcs_pkg::dly_us(dsel);
      o_delay_rsvd <= dsel == 4'h0;
      o_trip_mv    <= cbcs_pkg::trip_mv(tsel, i_sense_gain_range);
      o_volt_mv    <= cbcs_pkg::VOLT_TOP_MV - cbcs_pkg::VOLT_STEP * 12'(i_balance_volt_sel);
    end
  end

  default clocking dcb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  delay_step_a: assert property (
    i_ce && dsel != 4'h0 |=> int'(o_delay_us) == 60 * int'($past(dsel)) + 60 && !o_delay_rsvd)
    else $error("charge short delay wrong");
  trip_level_a: assert property (
    i_ce |=> int'(o_trip_mv) == ($past(i_sense_gain_range)
      ? 50 + 25 * int'($past(tsel)) : 10 + 5 * int'($past(tsel))))
    else $error("charge short trip wrong");
  volt_thresh_a: assert property (
    i_ce |=> int'(o_volt_mv) == 3900 - 100 * int'($past(i_balance_volt_sel)))
    else $error("balance threshold wrong");
endmodule : cbcs_decode
`default_nettype wire

// ### logic/cbcs_top.sv
`timescale 1ns/1ns
`default_nettype none
module cbcs_top #(
  parameter int unsigned TICK_CYCLES   = cbcs_pkg::TICK_CYCLES,
  parameter int unsigned SECS_PER_HOUR = cbcs_pkg::SECS_PER_HOUR
) (
  // clock, reset, enable
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // analog side
  input  wire logic        i_charger_present,
  input  wire logic [7:0]  i_cell_at_thresh,
  output logic      [7:0]  o_bleed_en,
  // decoded settings
  output logic      [9:0]  o_chg_short_delay_us,
  output logic             o_chg_short_delay_rsvd,
  output logic      [10:0] o_chg_short_delay_applied_us,
  output logic      [8:0]  o_chg_short_trip_mv,
  output logic             o_sense_gain_range,
  output logic      [11:0] o_balance_volt_mv,
  // status
  output logic             o_balancing,
  output logic             o_irq
);
  // ********************************
  // configuration registers
  // ********************************
  logic [7:0]  chg_short_config_q;
  logic [7:0]  cell_balance_config_q;
  logic        sense_gain_range_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic [31:0] prdata_q;
  logic        rdy_q;
  logic [1:0]  mode_prev_q;
  logic [7:0]  bleed_q;
  cbcs_pkg::cbcs_state_type state_q;
  cbcs_pkg::cbcs_state_type state_d;

  wire [1:0] balance_mode_sel    = cell_balance_config_q[cbcs_pkg::MODE_LSB +: 2];
  wire [1:0] balance_timeout_sel = cell_balance_config_q[cbcs_pkg::TMO_LSB +: 2];
  wire [3:0] balance_volt_sel    = cell_balance_config_q[cbcs_pkg::VOLT_LSB +: 4];

  // ********************************
  // apb decode
  // ********************************
  wire [5:0] idx      = i_paddr[7:2];
  wire       hit_rng  = idx == cbcs_pkg::IDX_SENSE_RANGE;
  wire       hit_chs  = idx == cbcs_pkg::IDX_CHG_SHORT;
  wire       hit_bal  = idx == cbcs_pkg::IDX_CELL_BAL;
  wire       hit_st   = idx == cbcs_pkg::IDX_STATUS;
  wire       hit_ist  = idx == cbcs_pkg::IDX_IRQ_STAT;
  wire       hit_imk  = idx == cbcs_pkg::IDX_IRQ_MASK;
  wire       hit_any  = hit_rng | hit_chs | hit_bal | hit_st | hit_ist | hit_imk;
  // a transfer completes only while enabled, so a frozen block stalls the bus
  wire       wr_en    = i_psel & i_penable & o_pready & i_pwrite & hit_any;
  wire [2:0] irq_clr  = (wr_en & hit_ist) ? i_pwdata[2:0] : 3'h0;
  wire [31:0] status_word = {16'h0, bleed_q, 5'h0, i_charger_present,
                             state_q == cbcs_pkg::ST_LOCK, state_q == cbcs_pkg::ST_BAL};
  wire [31:0] rd_mux =
      hit_rng ? {31'h0, sense_gain_range_q} :
      hit_chs ? {24'h0, chg_short_config_q} :
      hit_bal ? {24'h0, cell_balance_config_q} :
      hit_st  ? status_word :
      hit_ist ? {29'h0, irq_stat_q} :
      hit_imk ? {29'h0, irq_mask_q} : 32'h0;

  assign o_pready  = i_ce & rdy_q;
  assign o_pslverr = i_psel & i_penable & o_pready & ~hit_any;
  assign o_prdata  = prdata_q;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdy_q    <= 1'b0;
      prdata_q <= 32'h0;
    end
    else if (i_ce)
    begin
      rdy_q <= i_psel & ~(i_penable & rdy_q);
      if (i_psel && !rdy_q)
        prdata_q <= rd_mux;
    end
  end

  // ********************************
  // register writes and interrupts
  // ********************************
  wire       mode_chg  = balance_mode_sel != mode_prev_q;
  wire       ev_start  = state_q != cbcs_pkg::ST_BAL && state_d == cbcs_pkg::ST_BAL;
  wire       ev_tmo    = state_q == cbcs_pkg::ST_BAL && state_d == cbcs_pkg::ST_LOCK;
  wire       ev_stop   = state_q == cbcs_pkg::ST_BAL && state_d == cbcs_pkg::ST_IDLE;
  wire [2:0] irq_set   = {ev_stop, ev_tmo, ev_start};

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cell_balance_config_q <= cbcs_pkg::RST_CFG;
      chg_short_config_q    <= cbcs_pkg::RST_CFG;
      sense_gain_range_q    <= 1'b0;
      irq_mask_q            <= cbcs_pkg::RST_MASK;
      irq_stat_q            <= 3'h0;
    end
    else if (i_ce)
    begin
      if (wr_en && hit_chs)
        chg_short_config_q <= i_pwdata[7:0];
      if (wr_en && hit_bal)
        cell_balance_config_q <= i_pwdata[7:0];
      if (wr_en && hit_rng)
        sense_gain_range_q <= i_pwdata[0];
      if (wr_en && hit_imk)
        irq_mask_q <= i_pwdata[2:0];
      // set wins over a write-one clear in the same cycle
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ********************************
  // balancing controller
  // ********************************
  wire any_at   = |i_cell_at_thresh;
  wire timed    = balance_mode_sel[0];
  wire chg_need = balance_mode_sel[1];
  wire tmr_exp;

  cbcs_tmr_if tmr_if ();

  always_comb
  begin
    state_d = state_q;
    if (mode_chg || balance_mode_sel == cbcs_pkg::MODE_OFF)
      state_d = cbcs_pkg::ST_IDLE;
    else
    begin
      unique case (state_q)
        cbcs_pkg::ST_IDLE:
        begin
          if (any_at && (!chg_need || i_charger_present))
            state_d = cbcs_pkg::ST_BAL;
        end
        cbcs_pkg::ST_BAL:
        begin
          if (chg_need && !i_charger_present)
            state_d = cbcs_pkg::ST_IDLE;
          else if (timed && tmr_exp)
            state_d = cbcs_pkg::ST_LOCK;
        end
        cbcs_pkg::ST_LOCK:
        begin
          if (!chg_need && !any_at)
            state_d = cbcs_pkg::ST_IDLE;
          else if (chg_need && !i_charger_present)
            state_d = cbcs_pkg::ST_IDLE;
        end
        default:
          state_d = cbcs_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q     <= cbcs_pkg::ST_IDLE;
      mode_prev_q <= cbcs_pkg::MODE_OFF;
      bleed_q     <= 8'h00;
    end
    else if (i_ce)
    begin
      state_q     <= state_d;
      mode_prev_q <= balance_mode_sel;
      bleed_q     <= (state_d == cbcs_pkg::ST_BAL) ? i_cell_at_thresh : 8'h00;
    end
  end

  assign o_bleed_en  = bleed_q;
  assign o_balancing = state_q == cbcs_pkg::ST_BAL;

  assign tmr_if.run   = timed && state_q == cbcs_pkg::ST_BAL;
  assign tmr_if.clear = mode_chg || balance_mode_sel == cbcs_pkg::MODE_OFF;
  assign tmr_if.sel   = balance_timeout_sel;
  assign tmr_exp      = tmr_if.expired;

  cbcs_timer #(
    .TICK_CYCLES   (TICK_CYCLES),
    .SECS_PER_HOUR (SECS_PER_HOUR)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .tif        (tmr_if.tmr)
  );

  // ********************************
  // decoded settings
  // ********************************
  cbcs_decode u_decode (
    .i_core_clk         (i_core_clk),
    .i_rst              (i_rst),
    .i_ce               (i_ce),
    .i_chg_short_config (chg_short_config_q),
    .i_sense_gain_range (sense_gain_range_q),
    .i_balance_volt_sel (balance_volt_sel),
    .o_delay_us         (o_chg_short_delay_us),
    .o_delay_rsvd       (o_chg_short_delay_rsvd),
    .o_trip_mv          (o_chg_short_trip_mv),
    .o_volt_mv          (o_balance_volt_mv)
  );

  assign o_sense_gain_range = sense_gain_range_q;
  assign o_chg_short_delay_applied_us = o_balancing ? {o_chg_short_delay_us, 1'b0}
                                                    : {1'b0, o_chg_short_delay_us};

  // ********************************
  // checks
  // ********************************
  default clocking mcb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  bleed_gate_a: assert property (
    state_q != cbcs_pkg::ST_BAL |-> o_bleed_en == 8'h00)
    else $error("bleeding outside balancing");
  mode_off_a: assert property (
    i_ce && balance_mode_sel == cbcs_pkg::MODE_OFF |=> !o_balancing && o_bleed_en == 8'h00)
    else $error("balancing in mode off");
  start_bal_a: assert property (
    i_ce && !mode_chg && state_q == cbcs_pkg::ST_IDLE
    && balance_mode_sel == cbcs_pkg::MODE_ALWAYS && any_at
    |=> o_balancing && o_bleed_en == $past(i_cell_at_thresh))
    else $error("mode 01 did not start");
  rearm_wait_a: assert property (
    i_ce && !mode_chg && state_q == cbcs_pkg::ST_LOCK
    && balance_mode_sel == cbcs_pkg::MODE_ALWAYS && any_at
    |=> state_q == cbcs_pkg::ST_LOCK)
    else $error("mode 01 rearmed early");
  chg_drop_a: assert property (
    i_ce && o_balancing && chg_need && !i_charger_present
    |=> o_bleed_en == 8'h00 && !o_balancing)
    else $error("bleed kept after charger removal");
  relock_chg_a: assert property (
    i_ce && !mode_chg && state_q == cbcs_pkg::ST_LOCK
    && balance_mode_sel == cbcs_pkg::MODE_CHG_TO && i_charger_present
    |=> state_q == cbcs_pkg::ST_LOCK)
    else $error("mode 11 rearmed without charger cycle");
  timeout_stop_a: assert property (
    i_ce && !mode_chg && o_balancing && timed && tmr_exp
    && (!chg_need || i_charger_present)
    |=> state_q == cbcs_pkg::ST_LOCK ##0 irq_stat_q[cbcs_pkg::IRQ_TMO])
    else $error("timeout did not end balancing");
  delay_double_a: assert property (
    o_balancing |-> o_chg_short_delay_applied_us == 11'(o_chg_short_delay_us) * 11'h2)
    else $error("applied delay not doubled");
  hold_bal_a: assert property (
    i_ce && !mode_chg && o_balancing && balance_mode_sel == cbcs_pkg::MODE_ALWAYS && !tmr_exp
    |=> o_balancing)
    else $error("mode 01 stopped before expiry");
  lock_leave_a: assert property (
    i_ce && !mode_chg && state_q == cbcs_pkg::ST_LOCK
    && balance_mode_sel == cbcs_pkg::MODE_ALWAYS && !any_at
    |=> state_q == cbcs_pkg::ST_IDLE)
    else $error("mode 01 lockout not released");
  chg_rearm_a: assert property (
    i_ce && !mode_chg && state_q == cbcs_pkg::ST_LOCK
    && balance_mode_sel == cbcs_pkg::MODE_CHG_TO && !i_charger_present
    |=> state_q == cbcs_pkg::ST_IDLE)
    else $error("mode 11 lockout not released");
  chg_start_a: assert property (
    i_ce && !mode_chg && !o_balancing && chg_need && !i_charger_present
    |=> !o_balancing)
    else $error("balancing began without charger");
  no_lock_chg_a: assert property (
    i_ce && !mode_chg && balance_mode_sel == cbcs_pkg::MODE_CHG
    |=> state_q != cbcs_pkg::ST_LOCK)
    else $error("mode 10 timed out");
  idle_timer_a: assert property (
    i_ce && state_q == cbcs_pkg::ST_IDLE
    |=> !tmr_exp)
    else $error("timer ran before diversion");
  mode_clear_a: assert property (
    i_ce && mode_chg
    |=> !o_balancing && !tmr_exp)
    else $error("mode change kept timer or balancing");
  bleed_follow_a: assert property (
    i_ce && state_d == cbcs_pkg::ST_BAL |=> o_bleed_en == $past(i_cell_at_thresh))
    else $error("bleed does not follow comparators");

  // ********************************
  // register side checks
  // ********************************
  // a set in the clearing cycle must survive, or software could lose an event
  tmo_flag_a: assert property (
    i_ce && ev_tmo |=> irq_stat_q[cbcs_pkg::IRQ_TMO])
    else $error("timeout flag lost");
  start_clear_a: assert property (
    i_ce && irq_clr[cbcs_pkg::IRQ_START] && !ev_start |=> !irq_stat_q[cbcs_pkg::IRQ_START])
    else $error("start flag not cleared");
  bal_write_a: assert property (
    wr_en && hit_bal |=> cell_balance_config_q == $past(i_pwdata[7:0]))
    else $error("balance config write lost");
  chs_write_a: assert property (
    wr_en && hit_chs |=> chg_short_config_q == $past(i_pwdata[7:0]))
    else $error("charge short config write lost");
  rng_write_a: assert property (
    wr_en && hit_rng |=> sense_gain_range_q == $past(i_pwdata[0]))
    else $error("sense range write lost");
  ce_freeze_a: assert property (
    !i_ce |=> $stable(state_q) && $stable(o_bleed_en) && $stable(irq_stat_q))
    else $error("state moved while disabled");
  ready_next_a: assert property (
    i_ce && i_psel && !i_penable |=> rdy_q)
    else $error("no ready after setup");
endmodule : cbcs_top
`default_nettype wire

// ### test/cbcs_cell_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************
// analog side: charger detect, cell comparators, bleed switches
// ********************************
module cbcs_cell_model (
  // clock
  input  wire logic       i_core_clk,
  // bleed switches
  input  wire logic [7:0] i_bleed_en,
  // charger and comparators
  output logic            o_charger_present,
  output logic      [7:0] o_cell_at_thresh,
  output logic      [7:0] o_bled_cells
);
  logic       chg_q  = 1'b0;
  logic [7:0] cell_q = 8'h00;
  logic [7:0] bled_q = 8'h00;
  assign o_charger_present = chg_q;
  assign o_cell_at_thresh  = cell_q;
  assign o_bled_cells      = bled_q;
  // levels change only after an edge so the core never sees a half-set bus
  // charger may hold maintenance charge
  task automatic set_chg(input logic v);
    @(posedge i_core_clk);
    chg_q <= v;
  endtask : set_chg
  task automatic set_cells(input logic [7:0] v);
    @(posedge i_core_clk);
    cell_q <= v;
  endtask : set_cells
  // record which switches ever closed; bleeding is slow next to a sim run
  always @(posedge i_core_clk)
  begin
    bled_q <= bled_q | i_bleed_en;
  end
endmodule : cbcs_cell_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  // small tick so one hour is 12 cycles
  localparam int TK = 4;
  localparam int SH = 3;
  localparam int HR = TK * SH;
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        i_ce       = 1'b1;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [7:0]  i_paddr    = 8'h00;
  logic [31:0] i_pwdata   = 32'h00000000;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_chg, o_dly_rsvd, o_rng, o_bal, o_irq;
  wire  [7:0]  o_cells, o_bleed, o_bled;
  wire  [9:0]  o_dly;
  wire  [10:0] o_dly_app;
  wire  [8:0]  o_trip;
  wire  [11:0] o_volt;
  int          fail_count  = 0;
  int          check_count = 0;
  logic [31:0] rd;
  logic        er;
  int          n;
  always #20 i_core_clk = ~i_core_clk;
  cbcs_top #(.TICK_CYCLES(TK), .SECS_PER_HOUR(SH)) uut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_charger_present(o_chg), .i_cell_at_thresh(o_cells), .o_bleed_en(o_bleed),
    .o_chg_short_delay_us(o_dly), .o_chg_short_delay_rsvd(o_dly_rsvd),
    .o_chg_short_delay_applied_us(o_dly_app), .o_chg_short_trip_mv(o_trip),
    .o_sense_gain_range(o_rng), .o_balance_volt_mv(o_volt), .o_balancing(o_bal),
    .o_irq(o_irq));
  cbcs_cell_model model (
    .i_core_clk(i_core_clk), .i_bleed_en(o_bleed), .o_charger_present(o_chg),
    .o_cell_at_thresh(o_cells), .o_bled_cells(o_bled));
  // ********************************
  // access and compare tasks
  // ********************************
  task automatic stop_test;
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_in(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_in
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_core_clk);
      k++;
    end
    while (o_pready !== 1'b1 && k < 50);
    if (k >= 50)
      chk_val(32'h1, 32'h0);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wait_bal(input logic lvl, input int lim);
    n = 0;
    while (o_bal !== lvl && n < lim)
    begin
      @(posedge i_core_clk);
      n++;
    end
  endtask : wait_bal
  task automatic settle;
    repeat (3) @(posedge i_core_clk);
  endtask : settle
  // ********************************
  // test sequence
  // ********************************
  initial
  begin
    #(40 * 20000);
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    settle;
    apb(0, 8'h28, 0);
    chk_val(rd, 32'h0); // default mode off
    apb(0, 8'hFC, 0);
    chk_val({31'h0, er}, 32'h1); // unmapped index
    chk_val({21'h0, o_dly, o_dly_rsvd}, {21'h0, 10'h03C, 1'b1}); // reserved code
    for (int k = 0; k < 16; k++)
    begin
      apb(1, 8'h24, {24'h0, 4'(k), 4'(k)});
      apb(0, 8'h24, 0);
      chk_val(rd, {24'h0, 4'(k), 4'(k)}); // field layout
      for (int r = 0; r < 2; r++)
      begin
        apb(1, 8'h1C, 32'(r));
        settle;
        chk_val(32'(o_dly), 32'(60 * k + 60)); // delay step
        chk_val(32'(o_dly_rsvd), 32'(k == 0)); // reserved flag
        chk_val(32'(o_trip), 32'(r ? 50 + 25 * k : 10 + 5 * k)); // trip
        chk_val(32'(o_rng), 32'(r)); // range bit
      end
      apb(1, 8'h28, 32'(k));
      settle;
      chk_val(32'(o_volt), 32'(3900 - 100 * k)); // threshold
    end
    apb(1, 8'h28, 32'h00);
    apb(1, 8'h48, 32'h1);
    model.set_chg(1);
    model.set_cells(8'h08);
    settle;
    chk_val(32'(o_bal), 32'h0); // mode off
    apb(1, 8'h28, 32'h40);
    wait_bal(1, 10);
    chk_val({o_bleed, 5'h0, o_dly_app}, {8'h08, 5'h0, 11'h780});
    chk_val(32'(o_irq), 32'h1); // start event
    apb(1, 8'h44, 32'h1);
    settle;
    chk_val(32'(o_irq), 32'h0); // start event cleared
    model.set_chg(0);
    wait_bal(0, 60);
    chk_in(n, HR - 6, HR + 4); // one hour
    repeat (20) @(posedge i_core_clk);
    chk_val(32'(o_bal), 32'h0); // no restart yet
    apb(0, 8'h40, 0);
    chk_val(rd, 32'h2); // lockout status
    apb(0, 8'h44, 0);
    chk_val(rd, 32'h2); // timeout flag
    model.set_cells(8'h00);
    settle;
    model.set_cells(8'h81);
    wait_bal(1, 10);
    chk_val(32'(o_bleed), 32'h81); // rearm
    apb(1, 8'h28, 32'h80);
    model.set_cells(8'h04);
    settle;
    chk_val(32'(o_bal), 32'h0); // charger needed
    model.set_chg(1);
    wait_bal(1, 10);
    i_ce <= 1'b0;
    model.set_cells(8'h00);
    settle;
    chk_val({o_bal, o_bleed}, 32'h104); // frozen while disabled
    i_ce <= 1'b1;
    model.set_cells(8'h04);
    repeat (8 * HR) @(posedge i_core_clk);
    chk_val({o_bal, o_bleed}, 32'h104); // no timeout
    model.set_chg(0);
    wait_bal(0, 5);
    chk_val(32'(o_bal), 32'h0); // stop on removal
    apb(1, 8'h28, 32'hD0);
    model.set_chg(1);
    wait_bal(1, 10);
    wait_bal(0, 100);
    chk_in(n, 2 * HR - 6, 2 * HR + 4); // two hours
    repeat (20) @(posedge i_core_clk);
    chk_val(32'(o_bal), 32'h0); // lockout
    model.set_chg(0);
    settle;
    model.set_chg(1);
    wait_bal(1, 10);
    chk_val(32'(o_bal), 32'h1); // charger cycle
    apb(1, 8'h28, 32'h70);
    wait_bal(0, 5);
    wait_bal(1, 10);
    wait_bal(0, 200);
    chk_in(n, 8 * HR - 6, 8 * HR + 4); // eight hours
    model.set_cells(8'h00);
    settle;
    model.set_cells(8'h04);
    wait_bal(1, 10);
    apb(1, 8'h28, 32'h00);
    settle;
    chk_val({o_bal, o_bleed}, 32'h0); // disable
    chk_val(32'(o_bled), 32'h8D); // cells bled
    stop_test;
  end
endmodule : tb
`default_nettype wire
